// ---- sacps_supervisor.sv ----
// Supply and AC-line protection supervisor for a boost plus flyback controller.
// Assumes all comparator inputs are synchronous to i_ref_clk.
//
// Notes on behaviour
// - Lock-out has separate assert and release levels and clears itself.
// - Leaving lock-out enables the flyback converter before anything else.
// - Supply below lock-out assert level re-enters lock-out, halting both converters.
// - Over-voltage counts only after the comparator stays high for the mask time.
// - Confirmed over-voltage latches both converters off; mask time is a parameter.
// - Charge path starts below charge start level, only after flyback running.
// - Boost output held off while the charge path is active.
// - Above charge stop level charging ends and boost may resume.
// - Qualified forced stop latches both converters off.
// - Flyback may start only with AC sense above the brown-in level.
// - AC sense low for the brownout timer after start-up stops both converters.
// - Discharge permitted after brownout timeout; it acts while charging.
// - Nine uninterrupted high-peak line cycles select high-mains mode.
// - High mains selects the higher boost reference, else the lower one.
// - Mains mode switches the flyback over-current level.
// - High mains with boost running scales the over-current level down.
// - Boost enabled only after flyback soft start done and flyback normal.
`timescale 1ns/1ps
`default_nettype none
module sacps_supervisor #(
   parameter int unsigned OVP_MASK_TICKS = sacps_pkg::OVP_MASK_TICKS,
   parameter int unsigned BROWNOUT_TICKS = sacps_pkg::BROWNOUT_TICKS
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_vcc_above_release,
   input wire logic i_vcc_below_assert,
   input wire logic i_vcc_over,
   input wire logic i_vcc_below_charge_start,
   input wire logic i_vcc_above_charge_stop,
   input wire logic i_vcc_below_latch_release,
   input wire logic i_stop_pin_low,
   input wire logic i_ac_above_brownout,
   input wire logic i_ac_above_mains_detect,
   input wire logic i_flyback_ss_done,
   input wire logic i_flyback_normal,
   output logic o_flyback_en,
   output logic o_boost_en,
   output logic o_charge_en,
   output logic o_xcap_discharge,
   output logic o_boost_ref_high,
   output logic [1:0] o_ocp_level_sel,
   output logic o_lockout,
   output logic o_ovp_latched,
   output logic o_stop_latched,
   output logic o_brownout
);
   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   sacps_pkg::sacps_state_t state_q;
   sacps_pkg::sacps_state_t state_d;
   logic [sacps_pkg::TICK_W-1:0] tick_cnt_q;
   logic tick_q;
   logic lockout_q;
   logic ovp_lat_q;
   logic stop_lat_q;
   logic charge_q;
   logic fly_seen_q;
   logic xcap_arm_q;
   logic bo_seen_q;
   logic ac_prev_q;
   logic ovp_met;
   logic stop_met;
   logic bo_met;
   logic bo_cond;
   logic any_latch;
   logic high_mains;
   logic cycle_start;
   logic boost_run;

   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   // One tick each microsecond keeps the long timers narrow
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= (tick_cnt_q == sacps_pkg::TICK_LAST);
         if (tick_cnt_q == sacps_pkg::TICK_LAST) begin
            tick_cnt_q <= '0;
         end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Persistence timers
   // ---------------------------------------------------------------
   // Over-voltage mask, shorter surges never reach the latch
   sacps_persist_timer u_ovp_tmr (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_tick(tick_q),
      .i_cond(i_vcc_over),
      .i_limit(sacps_pkg::TMR_W'(OVP_MASK_TICKS)),
      .o_met(ovp_met)
   );

   // Forced-stop debounce against noise on the pin
   sacps_persist_timer u_stop_tmr (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_tick(tick_q),
      .i_cond(i_stop_pin_low),
      .i_limit(sacps_pkg::TMR_W'(sacps_pkg::STOP_DEBOUNCE_TICKS)),
      .o_met(stop_met)
   );

   // Brownout only counts once the flyback has been started
   assign bo_cond = fly_seen_q && !i_ac_above_brownout;

   sacps_persist_timer u_bo_tmr (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_tick(tick_q),
      .i_cond(bo_cond),
      .i_limit(sacps_pkg::TMR_W'(BROWNOUT_TICKS)),
      .o_met(bo_met)
   );

   // ---------------------------------------------------------------
   // Mains detection
   // ---------------------------------------------------------------
   // Rise of the brown-in comparator marks each new line cycle
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ac_prev_q <= 1'b0;
      end else begin
         ac_prev_q <= i_ac_above_brownout;
      end
   end

   assign cycle_start = i_ac_above_brownout && !ac_prev_q;

   sacps_mains_detect u_mains (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_cycle_start(cycle_start),
      .i_peak_high(i_ac_above_mains_detect),
      .i_clear(i_vcc_below_latch_release),
      .o_high_mains(high_mains)
   );

   // ---------------------------------------------------------------
   // Lock-out and latches
   // ---------------------------------------------------------------
   // Hysteresis: assert level wins if both comparators disagree
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         lockout_q <= 1'b1;
      end else if (i_vcc_below_assert) begin
         lockout_q <= 1'b1;
      end else if (i_vcc_above_release) begin
         lockout_q <= 1'b0;
      end
   end

   // Set beats the release level so no event is lost
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ovp_lat_q <= 1'b0;
      end else if (ovp_met) begin
         ovp_lat_q <= 1'b1;
      end else if (i_vcc_below_latch_release) begin
         ovp_lat_q <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         stop_lat_q <= 1'b0;
      end else if (stop_met) begin
         stop_lat_q <= 1'b1;
      end else if (i_vcc_below_latch_release) begin
         stop_lat_q <= 1'b0;
      end
   end

   assign any_latch = ovp_lat_q || stop_lat_q;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Latch first, then lock-out, then brownout, then normal steps
   always_comb begin
      state_d = state_q;
      if (any_latch) begin
         state_d = sacps_pkg::SACPS_LATCHED;
      end else if (lockout_q) begin
         state_d = sacps_pkg::SACPS_LOCKOUT;
      end else begin
         case (state_q)
            sacps_pkg::SACPS_LOCKOUT: begin
               if (i_ac_above_brownout) begin
                  state_d = sacps_pkg::SACPS_FLYBACK;
               end
            end
            sacps_pkg::SACPS_FLYBACK: begin
               if (bo_met) begin
                  state_d = sacps_pkg::SACPS_LOCKOUT;
               end else if (i_flyback_ss_done && i_flyback_normal) begin
                  state_d = sacps_pkg::SACPS_RUN;
               end
            end
            sacps_pkg::SACPS_RUN: begin
               if (bo_met) begin
                  state_d = sacps_pkg::SACPS_LOCKOUT;
               end
            end
            sacps_pkg::SACPS_LATCHED: begin
               state_d = sacps_pkg::SACPS_LOCKOUT;
            end
            default: begin
               state_d = sacps_pkg::SACPS_LOCKOUT;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= sacps_pkg::SACPS_LOCKOUT;
      end else begin
         state_q <= state_d;
      end
   end

   // Flyback has run since lock-out released; gates charge and brownout
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         fly_seen_q <= 1'b0;
      end else if (lockout_q) begin
         fly_seen_q <= 1'b0;
      end else if (state_q == sacps_pkg::SACPS_FLYBACK) begin
         fly_seen_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Charge path and discharge
   // ---------------------------------------------------------------
   // Charging also continues after a brownout so discharge can act
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         charge_q <= 1'b0;
      end else if (lockout_q || !fly_seen_q) begin
         charge_q <= 1'b0;
      end else if (i_vcc_above_charge_stop) begin
         charge_q <= 1'b0;
      end else if (i_vcc_below_charge_start) begin
         charge_q <= 1'b1;
      end
   end

   // Armed by the brownout timeout; AC return disarms, set wins
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         xcap_arm_q <= 1'b0;
         bo_seen_q <= 1'b0;
      end else begin
         if (bo_met) begin
            xcap_arm_q <= 1'b1;
         end else if (i_ac_above_brownout || lockout_q) begin
            xcap_arm_q <= 1'b0;
         end
         if (bo_met) begin
            bo_seen_q <= 1'b1;
         end else if (state_q == sacps_pkg::SACPS_FLYBACK || lockout_q) begin
            bo_seen_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   assign boost_run = (state_q == sacps_pkg::SACPS_RUN) && !charge_q;

   // Everything leaves from a flop, one cycle behind internal state
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_flyback_en <= 1'b0;
         o_boost_en <= 1'b0;
         o_charge_en <= 1'b0;
         o_xcap_discharge <= 1'b0;
         o_lockout <= 1'b1;
         o_ovp_latched <= 1'b0;
         o_stop_latched <= 1'b0;
         o_brownout <= 1'b0;
      end else begin
         o_flyback_en <= (state_q == sacps_pkg::SACPS_FLYBACK)
            || (state_q == sacps_pkg::SACPS_RUN);
         o_boost_en <= boost_run;
         o_charge_en <= charge_q;
         o_xcap_discharge <= xcap_arm_q && charge_q;
         o_lockout <= lockout_q;
         o_ovp_latched <= ovp_lat_q;
         o_stop_latched <= stop_lat_q;
         o_brownout <= bo_seen_q;
      end
   end

   // Mains mode steers the boost reference and flyback current limit
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_boost_ref_high <= 1'b0;
         o_ocp_level_sel <= sacps_pkg::OCP_LOW_MAINS;
      end else begin
         o_boost_ref_high <= high_mains;
         if (high_mains && boost_run) begin
            o_ocp_level_sel <= sacps_pkg::OCP_HIGH_BOOST;
         end else if (high_mains) begin
            o_ocp_level_sel <= sacps_pkg::OCP_HIGH_MAINS;
         end else begin
            o_ocp_level_sel <= sacps_pkg::OCP_LOW_MAINS;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   boost_vs_charge_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst) o_charge_en |-> !o_boost_en)
      else $error("boost enabled while charging");

   lockout_halt_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      i_vcc_below_assert |-> ##3 (!o_flyback_en && !o_boost_en))
      else $error("converters run under lock-out");

   boost_after_fly_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_boost_en) |-> $past(o_flyback_en))
      else $error("boost started before flyback");

   ovp_latch_hold_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (ovp_lat_q && !i_vcc_below_latch_release) |=> ##1 (!o_flyback_en && !o_boost_en))
      else $error("over-voltage latch did not stop converters");

   ovp_cause_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      $rose(ovp_lat_q) |-> $past(i_vcc_over, 1) && $past(i_vcc_over, 2))
      else $error("over-voltage latched without persistent input");

   stop_latch_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      $rose(stop_lat_q) |-> $past(i_stop_pin_low) ##1 o_stop_latched)
      else $error("forced stop latched without cause");

   fly_brownin_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_flyback_en) |-> $past(i_ac_above_brownout, 2))
      else $error("flyback started below brown-in");

   xcap_gate_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst) o_xcap_discharge |-> o_charge_en)
      else $error("discharge without charge path");

   ocp_boost_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (o_ocp_level_sel == sacps_pkg::OCP_HIGH_BOOST) |-> (o_boost_en && o_boost_ref_high))
      else $error("scaled current limit outside high-mains boost");

   latch_release_a: assert property (
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_vcc_below_latch_release && !ovp_met && !stop_met) |=> ##1 !o_ovp_latched)
      else $error("latch not released at release level");
endmodule
`default_nettype wire

// ---- sacps_pkg.sv ----
// Constants for the supply and AC-line protection supervisor.
// Assumes a 200 MHz reference clock and comparator levels synchronous to it.
`default_nettype none
package sacps_pkg;
   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned TICK_NS = 1000;
   localparam int unsigned TICK_CYCLES = (TICK_NS * CLK_MHZ) / 1000;
   localparam int unsigned TICK_W = 8;
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // ---------------------------------------------------------------
   // Persistence times, counted in time-base ticks of 1 us
   // ---------------------------------------------------------------
   localparam int unsigned TMR_W = 18;
   localparam int unsigned OVP_MASK_US = 150;
   localparam int unsigned STOP_DEBOUNCE_US = 150;
   localparam int unsigned BROWNOUT_MS = 256;
   localparam int unsigned OVP_MASK_TICKS = (OVP_MASK_US * 1000) / TICK_NS;
   localparam int unsigned STOP_DEBOUNCE_TICKS = (STOP_DEBOUNCE_US * 1000) / TICK_NS;
   localparam int unsigned BROWNOUT_TICKS = (BROWNOUT_MS * 1000000) / TICK_NS;

   // ---------------------------------------------------------------
   // Mains detection
   // ---------------------------------------------------------------
   localparam int unsigned MAINS_CNT_W = 4;
   localparam logic [MAINS_CNT_W-1:0] MAINS_CYCLES = 4'h9;

   // ---------------------------------------------------------------
   // Flyback over-current level selection
   // ---------------------------------------------------------------
   localparam logic [1:0] OCP_LOW_MAINS = 2'h0;
   localparam logic [1:0] OCP_HIGH_MAINS = 2'h1;
   localparam logic [1:0] OCP_HIGH_BOOST = 2'h2;

   // ---------------------------------------------------------------
   // Sequencer states, Gray coded along the start-up path
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SACPS_LOCKOUT = 2'h0,
      SACPS_FLYBACK = 2'h1,
      SACPS_RUN     = 2'h3,
      SACPS_LATCHED = 2'h2
   } sacps_state_t;
endpackage
`default_nettype wire

// ---- sacps_persist_timer.sv ----
// Persistence timer: reports a condition that has held for a number of ticks.
// Assumes i_tick is a one-cycle pulse from the shared time base.
`timescale 1ns/1ps
`default_nettype none
module sacps_persist_timer (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_tick,
   input wire logic i_cond,
   input wire logic [sacps_pkg::TMR_W-1:0] i_limit,
   output logic o_met
);
   logic [sacps_pkg::TMR_W-1:0] cnt_q;

   // Restart whenever the condition drops; saturate one past the limit
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= '0;
      end else if (!i_cond) begin
         cnt_q <= '0;
      end else if (i_tick && (cnt_q <= i_limit)) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // First tick may land just after the rise, so one extra tick keeps short pulses out
   assign o_met = i_cond && (cnt_q > i_limit);
endmodule
`default_nettype wire

// ---- sacps_mains_detect.sv ----
// Mains class detector: counts line cycles whose peak crossed the detect level.
// Assumes one i_cycle_start pulse per line cycle.
`timescale 1ns/1ps
`default_nettype none
module sacps_mains_detect (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_cycle_start,
   input wire logic i_peak_high,
   input wire logic i_clear,
   output logic o_high_mains
);
   logic [sacps_pkg::MAINS_CNT_W-1:0] cnt_q;
   logic seen_q;

   // Peak seen during the cycle now running
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         seen_q <= 1'b0;
      end else if (i_cycle_start || i_clear) begin
         seen_q <= 1'b0;
      end else if (i_peak_high) begin
         seen_q <= 1'b1;
      end
   end

   // One low cycle breaks the run
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= '0;
      end else if (i_clear) begin
         cnt_q <= '0;
      end else if (i_cycle_start) begin
         if (!seen_q) begin
            cnt_q <= '0;
         end else if (cnt_q < sacps_pkg::MAINS_CYCLES) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   // Sticky until the full-reset level
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_high_mains <= 1'b0;
      end else if (i_clear) begin
         o_high_mains <= 1'b0;
      end else if (cnt_q == sacps_pkg::MAINS_CYCLES) begin
         o_high_mains <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- sacps_analog_model.sv ----
// Partner model: comparators on the supply, the AC sense and the forced-stop pin.
// Assumes the bench sets levels in mV and the stop pin pull-down in ohms.
`timescale 1ns/1ps
`default_nettype none
module sacps_analog_model #(
   parameter int REL_MV = 13500,
   parameter int ASSERT_MV = 8200,
   parameter int OVER_MV = 27500,
   parameter int CHG_ON_MV = 11000,
   parameter int CHG_OFF_MV = 12500,
   parameter int LATCH_MV = 7000,
   parameter int BROWN_MV = 1000,
   parameter int MAINS_MV = 2500,
   parameter int STOP_OHM = 3700
) (
   input wire logic [15:0] i_vcc_mv,
   input wire logic [15:0] i_ac_mv,
   input wire logic [15:0] i_stop_ohm,
   output logic o_vcc_above_release,
   output logic o_vcc_below_assert,
   output logic o_vcc_over,
   output logic o_vcc_below_charge_start,
   output logic o_vcc_above_charge_stop,
   output logic o_vcc_below_latch_release,
   output logic o_stop_pin_low,
   output logic o_ac_above_brownout,
   output logic o_ac_above_mains_detect
);
   // ---------------------------------------------------------------
   // Ideal comparators
   // ---------------------------------------------------------------
   // No noise filtering here, so the bench alone decides every glitch
   assign o_vcc_above_release = int'(i_vcc_mv) > REL_MV;
   assign o_vcc_below_assert = int'(i_vcc_mv) < ASSERT_MV;
   assign o_vcc_over = int'(i_vcc_mv) > OVER_MV;
   assign o_vcc_below_charge_start = int'(i_vcc_mv) < CHG_ON_MV;
   assign o_vcc_above_charge_stop = int'(i_vcc_mv) > CHG_OFF_MV;
   assign o_vcc_below_latch_release = int'(i_vcc_mv) < LATCH_MV;
   assign o_ac_above_brownout = int'(i_ac_mv) > BROWN_MV;
   assign o_ac_above_mains_detect = int'(i_ac_mv) > MAINS_MV;
   // Only a pull-down stronger than the limit counts as a stop request
   assign o_stop_pin_low = int'(i_stop_ohm) < STOP_OHM;
endmodule
`default_nettype wire

// ---- tb_supply_ac_protection_supervisor.sv ----
// Testbench for the supply and AC-line protection supervisor.
// Assumes shortened OVP mask and brownout counts and a 1 us tick of 200 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_supply_ac_protection_supervisor;
   // ---------------------------------------------------------------
   // Stimulus, partner and design
   // ---------------------------------------------------------------
   localparam int TICK = 200;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_flyback_ss_done = 1'b0;
   logic i_flyback_normal = 1'b0;
   logic [15:0] vcc_mv = 16'h0000;
   logic [15:0] ac_mv = 16'h0000;
   logic [15:0] stop_ohm = 16'h4e20;
   wire i_vcc_above_release, i_vcc_below_assert, i_vcc_over, i_vcc_below_charge_start;
   wire i_vcc_above_charge_stop, i_vcc_below_latch_release, i_stop_pin_low;
   wire i_ac_above_brownout, i_ac_above_mains_detect;
   logic o_flyback_en, o_boost_en, o_charge_en, o_xcap_discharge, o_boost_ref_high;
   logic o_lockout, o_ovp_latched, o_stop_latched, o_brownout;
   logic [1:0] o_ocp_level_sel;
   int error_cnt = 0;
   int samples_checked = 0;
   int seed = 32'h641a;

   // Free-running 200 MHz clock
   always #2.5 i_ref_clk = ~i_ref_clk;

   sacps_analog_model model (.i_vcc_mv(vcc_mv), .i_ac_mv(ac_mv), .i_stop_ohm(stop_ohm),
      .o_vcc_above_release(i_vcc_above_release), .o_vcc_below_assert(i_vcc_below_assert),
      .o_vcc_over(i_vcc_over), .o_vcc_below_charge_start(i_vcc_below_charge_start),
      .o_vcc_above_charge_stop(i_vcc_above_charge_stop), .o_stop_pin_low(i_stop_pin_low),
      .o_vcc_below_latch_release(i_vcc_below_latch_release),
      .o_ac_above_brownout(i_ac_above_brownout),
      .o_ac_above_mains_detect(i_ac_above_mains_detect));

   // Short timers keep the run small; the forced-stop debounce stays full length
   sacps_supervisor #(.OVP_MASK_TICKS(3), .BROWNOUT_TICKS(20)) DUT (.i_ref_clk, .i_rst,
      .i_vcc_above_release, .i_vcc_below_assert, .i_vcc_over, .i_vcc_below_charge_start,
      .i_vcc_above_charge_stop, .i_vcc_below_latch_release, .i_stop_pin_low,
      .i_ac_above_brownout, .i_ac_above_mains_detect, .i_flyback_ss_done, .i_flyback_normal,
      .o_flyback_en, .o_boost_en, .o_charge_en, .o_xcap_discharge, .o_boost_ref_high,
      .o_ocp_level_sel, .o_lockout, .o_ovp_latched, .o_stop_latched, .o_brownout);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask

   function automatic int rnd(input int lo, input int span);
      return lo + int'($unsigned($random(seed)) % span);
   endfunction

   function automatic logic [10:0] outs();
      return {o_flyback_en, o_boost_en, o_charge_en, o_xcap_discharge, o_boost_ref_high,
         o_ocp_level_sel, o_lockout, o_ovp_latched, o_stop_latched, o_brownout};
   endfunction

   // Running state: boost held off by charging, OCP level follows mains and boost
   function automatic logic [10:0] exp_run(input logic boost, input logic chg, input logic hi);
      logic [1:0] ocp;
      ocp = sacps_pkg::OCP_LOW_MAINS;
      if (hi) begin
         ocp = boost ? sacps_pkg::OCP_HIGH_BOOST : sacps_pkg::OCP_HIGH_MAINS;
      end
      return {1'b1, boost, chg, 1'b0, hi, ocp, 4'h0};
   endfunction

   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Boost must wait for both soft start done and flyback judged normal
   task automatic start_up();
      i_flyback_ss_done <= 1'b0;
      i_flyback_normal <= 1'b0;
      vcc_mv <= 16'h36b0;
      ac_mv <= 16'h07d0;
      wait_clk(10);
      chk(outs(), exp_run(1'b0, 1'b0, 1'b0));
      i_flyback_ss_done <= 1'b1;
      wait_clk(10);
      chk(o_boost_en, 1'b0);
      i_flyback_normal <= 1'b1;
      wait_clk(10);
      chk(outs(), exp_run(1'b1, 1'b0, 1'b0));
      done("start-up");
   endtask

   task automatic release_latch();
      vcc_mv <= 16'h1770;
      wait_clk(10);
      chk(outs(), 11'h008);
      start_up();
   endtask

   // Line cycle: a short dip restarts the cycle, then a peak above or below mains level
   task automatic line_cycle(input logic peak);
      ac_mv <= 16'h0000;
      wait_clk(20);
      ac_mv <= peak ? 16'(rnd(2600, 800)) : 16'(rnd(1100, 1300));
      wait_clk(rnd(60, 60));
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      wait_clk(10);
      i_rst <= 1'b0;
      wait_clk(2);
      chk(outs(), 11'h008);
      vcc_mv <= 16'h36b0;
      ac_mv <= 16'h01f4;
      wait_clk(20);
      chk(o_flyback_en, 1'b0);
      start_up();
      vcc_mv <= 16'h1f40;
      wait_clk(10);
      chk(outs(), 11'h008);
      vcc_mv <= 16'h36b0;
      wait_clk(10);
      chk(outs(), exp_run(1'b1, 1'b0, 1'b0));
      done("lock-out");
      // Eight peaks, a broken cycle, then the count must start over
      for (int i = 0; i < 18; i++) line_cycle(i != 8);
      chk(o_boost_ref_high, 1'b0);
      line_cycle(1'b1);
      chk(outs(), exp_run(1'b1, 1'b0, 1'b1));
      ac_mv <= 16'h07d0;
      vcc_mv <= 16'h2710;
      wait_clk(10);
      chk(outs(), exp_run(1'b0, 1'b1, 1'b1));
      vcc_mv <= 16'h32c8;
      wait_clk(10);
      chk(outs(), exp_run(1'b1, 1'b0, 1'b1));
      done("mains and charge");
      // Surges shorter than one tick never reach the mask count
      repeat (4) begin
         vcc_mv <= 16'h6d60;
         wait_clk(rnd(20, 130));
         vcc_mv <= 16'h36b0;
         wait_clk(100);
      end
      chk(outs(), exp_run(1'b1, 1'b0, 1'b1));
      vcc_mv <= 16'h6d60;
      wait_clk(5 * TICK);
      chk({o_flyback_en, o_boost_en, o_boost_ref_high, o_ovp_latched}, 4'h3);
      release_latch();
      done("over-voltage");
      stop_ohm <= 16'h07d0;
      wait_clk(120 * TICK);
      stop_ohm <= 16'(rnd(4000, 20000));
      wait_clk(10);
      chk(outs(), exp_run(1'b1, 1'b0, 1'b0));
      stop_ohm <= 16'h07d0;
      wait_clk(160 * TICK);
      chk({o_flyback_en, o_boost_en, o_stop_latched}, 3'h1);
      stop_ohm <= 16'h4e20;
      release_latch();
      done("forced stop");
      vcc_mv <= 16'h2710;
      ac_mv <= 16'h0000;
      wait_clk(10 * TICK);
      chk({o_flyback_en, o_xcap_discharge, o_brownout}, 3'h4);
      ac_mv <= 16'h07d0;
      wait_clk(20);
      ac_mv <= 16'h0000;
      wait_clk(25 * TICK);
      chk({o_flyback_en, o_boost_en, o_charge_en, o_xcap_discharge, o_brownout}, 5'h07);
      done("brownout");
      print_verdict();
   end

   // Watchdog well past the expected run of about 70000 cycles
   initial begin
      wait_clk(150000);
      error_cnt++;
      print_verdict();
   end
endmodule
`default_nettype wire
